// ---- hw/serial_port0_uart.sv ----
// Serial port 0: control registers, transmitter and receiver.
`timescale 1ns/100ps
`default_nettype none
module serial_port0_uart
   import serial_port0_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire reg_req_s reg_req_in,
   output logic [7:0] rdata_out,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe_out,
   output logic txd_out,
   input wire logic rate_tick_in,
   input wire logic power_fail_irq_in,
   output logic serial_irq_out,
   output logic power_fail_req_out
);
   typedef struct packed {
      tx_state_e tx_st;
      rx_state_e rx_st;
      logic sm0;
      logic sm1;
      logic mp;
      logic ren;
      logic tb8;
      logic rb8;
      logic ti;
      logic ri;
      logic fe;
      logic fe_sel;
      logic dbl;
      logic [7:0] ie;
      logic [7:0] slave_match_value;
      logic [7:0] slave_match_mask;
      logic [7:0] rx_buf;
      logic [7:0] rdata;
      logic [10:0] tx_shift;
      logic [3:0] tx_idx;
      logic [SUB_W-1:0] tx_sub;
      logic m0_rx;
      logic m0_phase;
      logic [7:0] rx_shift;
      logic rx_ninth;
      logic [3:0] rx_idx;
      logic [SUB_W-1:0] rx_sub;
   } uart_s;

   localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(OVERSAMPLE - 1);
   localparam logic [SUB_W-1:0] SUB_HALF = SUB_W'(OVERSAMPLE / 2 - 1);
   localparam logic [3:0] DATA_LAST = 4'(DATA_BITS - 1);
   localparam logic [3:0] DATA_CNT = 4'(DATA_BITS);

   uart_s r;
   uart_s n;
   logic [1:0] mode;
   logic nine_bit;
   logic [3:0] stop_idx;
   logic samp_tick;
   logic sync_half;
   logic addr_match;
   reg_id_e wr_sel;
   reg_id_e rd_sel;

   function automatic reg_id_e reg_sel(input logic [7:0] addr);
      reg_id_e id;
      id = REG_NONE;
      if (addr == ADDR_POWER_CONTROL)
         id = REG_POWER;
      else if (addr == ADDR_SERIAL_CONTROL)
         id = REG_CONTROL;
      else if (addr == ADDR_SERIAL_BUFFER)
         id = REG_BUFFER;
      else if (addr == ADDR_IRQ_ENABLE)
         id = REG_IRQ_EN;
      else if (addr == ADDR_SLAVE_VALUE)
         id = REG_SLAVE_VAL;
      else if (addr == ADDR_SLAVE_MASK)
         id = REG_SLAVE_MASK;
      return id;
   endfunction

   assign mode = {r.sm0, r.sm1};
   assign nine_bit = r.sm0;
   assign stop_idx = nine_bit ? 4'(FRAME_BITS_11 - 1) :
      4'(FRAME_BITS_10 - 1);
   assign wr_sel = reg_sel(reg_req_in.addr);
   assign rd_sel = reg_sel(reg_req_in.addr);
   assign addr_match = ((r.rx_shift ^ r.slave_match_value) & r.slave_match_mask) == 8'h00;

   serial_rate_gen #(
      .SAMPLES(OVERSAMPLE)
   ) u_rate (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .mode_in(mode),
      .fast_sync_in(r.mp),
      .doubler_in(r.dbl),
      .rate_tick_in(rate_tick_in),
      .sync_run_in(r.tx_st == TX_SYNC),
      .samp_tick_out(samp_tick),
      .sync_half_out(sync_half)
   );

   always_comb
   begin
      n = r;
      n.rdata = READ_UNMAPPED;

      if (reg_req_in.rd)
      begin
         unique case (rd_sel)
            REG_POWER: n.rdata = {r.dbl, r.fe_sel, 6'h00};
            // Bit 7 shows the error flag or mode bit 0.
            REG_CONTROL: n.rdata = {r.fe_sel ? r.fe : r.sm0, r.sm1, r.mp,
               r.ren, r.tb8, r.rb8, r.ti, r.ri};
            REG_BUFFER: n.rdata = r.rx_buf;
            REG_IRQ_EN: n.rdata = r.ie;
            REG_SLAVE_VAL: n.rdata = r.slave_match_value;
            REG_SLAVE_MASK: n.rdata = r.slave_match_mask;
            REG_NONE: n.rdata = READ_UNMAPPED;
         endcase
      end

      if (reg_req_in.wr)
      begin
         unique case (wr_sel)
            REG_POWER:
            begin
               n.dbl = reg_req_in.wdata[PC_BAUD_DOUBLER];
               n.fe_sel = reg_req_in.wdata[PC_FRAME_ERROR_SELECT];
            end
            REG_CONTROL:
            begin
               // Only these writes clear the flags.
               if (r.fe_sel)
                  n.fe = reg_req_in.wdata[7];
               else
                  n.sm0 = reg_req_in.wdata[7];
               n.sm1 = reg_req_in.wdata[6];
               n.mp = reg_req_in.wdata[5];
               n.ren = reg_req_in.wdata[4];
               n.tb8 = reg_req_in.wdata[3];
               n.rb8 = reg_req_in.wdata[2];
               n.ti = reg_req_in.wdata[1];
               n.ri = reg_req_in.wdata[0];
            end
            REG_IRQ_EN: n.ie = reg_req_in.wdata;
            REG_SLAVE_VAL: n.slave_match_value = reg_req_in.wdata;
            REG_SLAVE_MASK: n.slave_match_mask = reg_req_in.wdata;
            REG_BUFFER: n.tx_idx = r.tx_idx;
            REG_NONE: n.tx_idx = r.tx_idx;
         endcase
      end

      unique case (r.tx_st)
         TX_IDLE:
         begin
            n.tx_idx = 4'h0;
            n.tx_sub = '0;
            n.m0_phase = 1'b0;
            if (reg_req_in.wr && wr_sel == REG_BUFFER)
            begin
               // A buffer write launches one frame.
               if (mode == MODE_SYNC)
               begin
                  n.tx_st = TX_SYNC;
                  n.m0_rx = 1'b0;
                  n.tx_shift = {3'h7, reg_req_in.wdata};
               end
               else
               begin
                  n.tx_st = TX_ASYNC;
                  // Ninth bit from software in 11-bit frames.
                  n.tx_shift = {1'b1, nine_bit ? r.tb8 : 1'b1,
                     reg_req_in.wdata, 1'b0};
               end
            end
            else if (mode == MODE_SYNC && r.ren && !r.ri)
            begin
               n.tx_st = TX_SYNC;
               n.m0_rx = 1'b1;
            end
         end
         TX_ASYNC:
         begin
            if (samp_tick)
            begin
               if (r.tx_sub == SUB_LAST)
               begin
                  n.tx_sub = '0;
                  n.tx_shift = {1'b1, r.tx_shift[10:1]};
                  n.tx_idx = r.tx_idx + 4'h1;
                  if (r.tx_idx + 4'h1 == stop_idx)
                     n.ti = 1'b1;
                  if (r.tx_idx == stop_idx)
                     n.tx_st = TX_IDLE;
               end
               else
                  n.tx_sub = r.tx_sub + 1'b1;
            end
         end
         TX_SYNC:
         begin
            if (r.m0_rx && !r.ren)
               n.tx_st = TX_IDLE;
            else if (sync_half)
            begin
               if (!r.m0_phase)
               begin
                  n.m0_phase = 1'b1;
                  if (r.m0_rx)
                     n.rx_shift = {rxd_in, r.rx_shift[7:1]};
               end
               else
               begin
                  n.m0_phase = 1'b0;
                  n.tx_idx = r.tx_idx + 4'h1;
                  if (!r.m0_rx)
                     n.tx_shift = {1'b1, r.tx_shift[10:1]};
                  if (r.tx_idx == DATA_LAST)
                  begin
                     n.tx_st = TX_IDLE;
                     if (r.m0_rx)
                     begin
                        n.rx_buf = r.rx_shift;
                        n.ri = 1'b1;
                     end
                     else
                        n.ti = 1'b1;
                  end
               end
            end
         end
         default:
            n.tx_st = TX_IDLE;
      endcase

      unique case (r.rx_st)
         RX_IDLE:
         begin
            n.rx_sub = '0;
            n.rx_idx = 4'h0;
            if (r.ren && mode != MODE_SYNC && samp_tick && !rxd_in)
               n.rx_st = RX_START;
         end
         RX_START:
         begin
            if (!r.ren)
               n.rx_st = RX_IDLE;
            else if (samp_tick)
            begin
               if (r.rx_sub == SUB_HALF)
               begin
                  n.rx_sub = '0;
                  n.rx_st = rxd_in ? RX_IDLE : RX_BITS;
               end
               else
                  n.rx_sub = r.rx_sub + 1'b1;
            end
         end
         RX_BITS:
         begin
            if (!r.ren)
               n.rx_st = RX_IDLE;
            else if (samp_tick)
            begin
               if (r.rx_sub == SUB_LAST)
               begin
                  n.rx_sub = '0;
                  n.rx_idx = r.rx_idx + 4'h1;
                  if (r.rx_idx < DATA_CNT)
                     n.rx_shift = {rxd_in, r.rx_shift[7:1]};
                  else if (r.rx_idx == DATA_CNT && nine_bit)
                     n.rx_ninth = rxd_in;
                  else
                  begin
                     // Middle of the stop bit ends the frame.
                     n.rx_st = RX_IDLE;
                     if (r.fe_sel && !rxd_in)
                        n.fe = 1'b1;
                     if (!nine_bit)
                     begin
                        if (!(r.mp && !rxd_in))
                        begin
                           n.rx_buf = r.rx_shift;
                           n.rb8 = rxd_in;
                           n.ri = 1'b1;
                        end
                     end
                     else if (!r.mp ||
                        (r.rx_ninth && addr_match))
                     begin
                        n.rx_buf = r.rx_shift;
                        n.rb8 = r.rx_ninth;
                        n.ri = 1'b1;
                     end
                  end
               end
               else
                  n.rx_sub = r.rx_sub + 1'b1;
            end
         end
         default:
            n.rx_st = RX_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         r <= '0;
         r.tx_st <= TX_IDLE;
         r.rx_st <= RX_IDLE;
         r.tx_shift <= 11'h7ff;
         {r.sm0, r.sm1, r.mp, r.ren, r.tb8, r.rb8, r.ti, r.ri} <=
            RST_SERIAL_CONTROL;
         r.rx_buf <= RST_SERIAL_BUFFER;
         r.ie <= RST_IRQ_ENABLE;
         r.slave_match_value <= RST_SLAVE_VALUE;
         r.slave_match_mask <= RST_SLAVE_MASK;
      end
      else
         r <= n;
   end

   assign rdata_out = r.rdata;
   assign rxd_out = r.tx_shift[0];
   assign rxd_oe_out = (r.tx_st == TX_SYNC) && !r.m0_rx;
   assign txd_out = (r.tx_st == TX_SYNC) ? r.m0_phase : r.tx_shift[0];
   // Serial request needs both enables; power-fail is never masked.
   assign serial_irq_out = r.ie[IE_GLOBAL] && r.ie[IE_SERIAL0] &&
      (r.ri || r.ti);
   assign power_fail_req_out = power_fail_irq_in;
endmodule
`default_nettype wire

// ---- inc/serial_port0_pkg.sv ----
// Constants, types and functional notes for serial port 0.
// Functional notes
// - Modes: 00 sync, 01 10-bit variable, 10 11-bit fixed, 11 11-bit variable.
// - Control bit 7 is mode bit 0, or the frame error flag when selected.
// - Frame error flag is set when a received stop bit is invalid, only while frame error select is 1.
// - Modes 2/3 with multiprocessor bit: no receive flag when ninth bit is 0.
// - Mode 1 with multiprocessor bit: no receive flag without valid stop bit.
// - Mode 0 shift clock is oscillator/12, or /4 with multiprocessor bit.
// - Reception happens only while receive enable is 1.
// - Modes 2/3 send the software ninth bit as ninth data bit.
// - Received ninth bit: data bit 9 in modes 2/3, stop bit in mode 1.
// - Transmit flag set after bit 8 in mode 0, at stop start otherwise.
// - Receive flag set after bit 8 in mode 0, mid stop bit otherwise.
// - Buffer address reads receive data and writes transmit data.
// - An 8-bit slave address register holds this port's own address.
// - Serial interrupt needs both serial enable and global enable.
// - Global enable gates every source except the power-fail interrupt.
// - Address match checks masked bits only; a zero mask matches anything.
// - Baud doubler doubles the bit rate in modes 1, 2 and 3.
`default_nettype none
package serial_port0_pkg;
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
   localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
   localparam logic [7:0] ADDR_SLAVE_VALUE = 8'ha9;
   localparam logic [7:0] ADDR_SLAVE_MASK = 8'hb9;

   localparam int PC_BAUD_DOUBLER = 7;
   localparam int PC_FRAME_ERROR_SELECT = 6;
   localparam int IE_GLOBAL = 7;
   localparam int IE_SERIAL0 = 4;

   localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
   localparam logic [7:0] RST_SERIAL_BUFFER = 8'h00;
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] RST_SLAVE_VALUE = 8'h00;
   localparam logic [7:0] RST_SLAVE_MASK = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_VAR10 = 2'h1;
   localparam logic [1:0] MODE_FIXED11 = 2'h2;
   localparam logic [1:0] MODE_VAR11 = 2'h3;

   localparam int OVERSAMPLE = 16;
   localparam int SUB_W = $clog2(OVERSAMPLE);
   localparam int M0_DIV_SLOW = 12;
   localparam int M0_DIV_FAST = 4;
   localparam int M2_DIV = 64;
   localparam int M2_DIV_DBL = 32;
   localparam int M0_HALF_SLOW = M0_DIV_SLOW / 2;
   localparam int M0_HALF_FAST = M0_DIV_FAST / 2;
   localparam int DATA_BITS = 8;
   localparam int FRAME_BITS_10 = 10;
   localparam int FRAME_BITS_11 = 11;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_ASYNC = 3'b010,
      TX_SYNC = 3'b100
   } tx_state_e;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_START = 3'b010,
      RX_BITS = 3'b100
   } rx_state_e;

   typedef enum logic [6:0] {
      REG_NONE = 7'b0000001,
      REG_POWER = 7'b0000010,
      REG_CONTROL = 7'b0000100,
      REG_BUFFER = 7'b0001000,
      REG_IRQ_EN = 7'b0010000,
      REG_SLAVE_VAL = 7'b0100000,
      REG_SLAVE_MASK = 7'b1000000
   } reg_id_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
endpackage
`default_nettype wire

// ---- hw/serial_rate_gen.sv ----
// Sample and shift tick generator for serial port 0.
`timescale 1ns/100ps
`default_nettype none
module serial_rate_gen
   import serial_port0_pkg::*;
#(
   parameter int SAMPLES = OVERSAMPLE
)
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [1:0] mode_in,
   input wire logic fast_sync_in,
   input wire logic doubler_in,
   input wire logic rate_tick_in,
   input wire logic sync_run_in,
   output logic samp_tick_out,
   output logic sync_half_out
);
   localparam int DIV_W = $clog2(M2_DIV);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic pre;
   } gen_s;

   gen_s r;
   gen_s nxt;
   logic [DIV_W-1:0] lim;

   generate
      if (SAMPLES < 2 || (M2_DIV_DBL % SAMPLES) != 0)
      begin : g_bad
         $error("SAMPLES must divide the fast mode 2 divisor");
      end
   endgenerate

   always_comb
   begin
      nxt = r;
      samp_tick_out = 1'b0;
      sync_half_out = 1'b0;
      lim = '0;
      unique case (mode_in)
         MODE_SYNC:
         begin
            // Shift clock half periods.
            lim = fast_sync_in ? DIV_W'(M0_HALF_FAST - 1) :
               DIV_W'(M0_HALF_SLOW - 1);
            if (!sync_run_in)
               nxt.cnt = '0;
            else if (r.cnt == lim)
            begin
               nxt.cnt = '0;
               sync_half_out = 1'b1;
            end
            else
               nxt.cnt = r.cnt + 1'b1;
         end
         MODE_FIXED11:
         begin
            // Fixed rate, halved divisor when doubled.
            lim = doubler_in ? DIV_W'(M2_DIV_DBL / SAMPLES - 1) :
               DIV_W'(M2_DIV / SAMPLES - 1);
            if (r.cnt >= lim)
            begin
               nxt.cnt = '0;
               samp_tick_out = 1'b1;
            end
            else
               nxt.cnt = r.cnt + 1'b1;
         end
         default:
         begin
            // External rate tick, every other one unless doubled.
            nxt.cnt = '0;
            if (rate_tick_in)
            begin
               nxt.pre = ~r.pre;
               samp_tick_out = doubler_in | r.pre;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         r <= '0;
      else
         r <= nxt;
   end
endmodule
`default_nettype wire

// ---- sim/serial_port0_monitor.sv ----
// Port-level assertions for serial port 0.
`timescale 1ns/100ps
`default_nettype none
module serial_port0_monitor
   import serial_port0_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire reg_req_s reg_req_in,
   input wire logic [7:0] rdata_out,
   input wire logic rxd_in,
   input wire logic rxd_out,
   input wire logic rxd_oe_out,
   input wire logic txd_out,
   input wire logic rate_tick_in,
   input wire logic power_fail_irq_in,
   input wire logic serial_irq_out,
   input wire logic power_fail_req_out
);
   logic [7:0] ie_r, sv_r, ctl_r, pc_r, a, d;
   logic sm0_r, wr, rd, mapped;
   logic [9:0] low_r;
   logic [1:0] mode;
   assign a = reg_req_in.addr;
   assign d = reg_req_in.wdata;
   assign wr = reg_req_in.wr;
   assign rd = reg_req_in.rd;
   assign mode = {sm0_r, ctl_r[6]};
   assign mapped = a == ADDR_POWER_CONTROL || a == ADDR_SERIAL_CONTROL
      || a == ADDR_SERIAL_BUFFER || a == ADDR_IRQ_ENABLE
      || a == ADDR_SLAVE_VALUE || a == ADDR_SLAVE_MASK;
   // Shadows of software-only register bits and a low-run counter.
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ie_r <= 8'h00;
         sv_r <= 8'h00;
         ctl_r <= 8'h00;
         pc_r <= 8'h00;
         sm0_r <= 1'b0;
         low_r <= 10'h000;
      end
      else
      begin
         if (wr && a == ADDR_IRQ_ENABLE)
            ie_r <= d;
         if (wr && a == ADDR_SLAVE_VALUE)
            sv_r <= d;
         if (wr && a == ADDR_POWER_CONTROL)
            pc_r <= d;
         if (wr && a == ADDR_SERIAL_CONTROL)
            ctl_r <= d;
         if (wr && a == ADDR_SERIAL_CONTROL && !pc_r[PC_FRAME_ERROR_SELECT])
            sm0_r <= d[7];
         if (txd_out)
            low_r <= 10'h000;
         else if (low_r != 10'h3ff)
            low_r <= low_r + 10'h001;
      end
   end
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   pf_pass_a: assert property (
      power_fail_req_out == power_fail_irq_in)
      else $error("power fail request differs from its source");
   rd_idle_a: assert property (!rd |=> rdata_out == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_a: assert property (
      rd && !mapped |=> rdata_out == READ_UNMAPPED)
      else $error("unmapped read returned data");
   ie_read_a: assert property (
      rd && a == ADDR_IRQ_ENABLE |=> rdata_out == $past(ie_r))
      else $error("interrupt enable read wrong");
   slave_read_a: assert property (
      rd && a == ADDR_SLAVE_VALUE |=> rdata_out == $past(sv_r))
      else $error("slave address read wrong");
   ctl_read_a: assert property (
      rd && a == ADDR_SERIAL_CONTROL |=>
      rdata_out[6:3] == $past(ctl_r[6:3]))
      else $error("control software bits read wrong");
   irq_gate_a: assert property (
      serial_irq_out |-> ie_r[IE_GLOBAL] && ie_r[IE_SERIAL0])
      else $error("serial interrupt without both enables");
   oe_mode_a: assert property (rxd_oe_out |-> mode == MODE_SYNC)
      else $error("data pin driven outside sync mode");
   m0_clk_a: assert property (
      mode == MODE_SYNC && $rose(txd_out) |->
      low_r == (ctl_r[5] ? 10'h002 : 10'h006))
      else $error("sync shift clock low half wrong");
   m2_bit_a: assert property (
      mode == MODE_FIXED11 && $rose(txd_out) |->
      low_r >= (pc_r[PC_BAUD_DOUBLER] ? 10'h01c : 10'h03c))
      else $error("fixed rate bit too short");
   cover property (rd && a == ADDR_SERIAL_BUFFER);
   cover property ($rose(serial_irq_out));
   cover property (rxd_oe_out && ctl_r[5]);
endmodule
bind serial_port0_uart serial_port0_monitor mon (.mclk_in(mclk_in),
   .resetn_in(resetn_in), .reg_req_in(reg_req_in), .rdata_out(rdata_out),
   .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_out(rxd_oe_out),
   .txd_out(txd_out), .rate_tick_in(rate_tick_in),
   .power_fail_irq_in(power_fail_irq_in), .serial_irq_out(serial_irq_out),
   .power_fail_req_out(power_fail_req_out));
`default_nettype wire

// ---- sim/serial_far_end.sv ----
// Remote serial end: sends async frames and captures sent ones.
`timescale 1ns/100ps
`default_nettype none
module serial_far_end
(
   input wire logic mclk_in,
   input wire logic txd_in,
   input wire logic data_in,
   output logic rxd_out
);
   int wait_n;
   initial rxd_out = 1'b1;
   task automatic wait_for(input logic v);
      wait_n = 0;
      while (txd_in !== v && wait_n < 2000)
      begin
         @(posedge mclk_in);
         wait_n++;
      end
   endtask
   // Sends a frame LSB first, then rests the line high for one bit time.
   task automatic send(input logic [10:0] f, input int n, input int bclk);
      @(posedge mclk_in);
      for (int i = 0; i < n; i++)
      begin
         rxd_out <= f[i];
         repeat (bclk) @(posedge mclk_in);
      end
      rxd_out <= 1'b1;
      repeat (bclk) @(posedge mclk_in);
   endtask
   // Presents one bit per shift clock, changed while the clock is low.
   task automatic feed_sync(input logic [7:0] d);
      for (int i = 0; i < 8; i++)
      begin
         wait_for(1'b0);
         rxd_out <= d[i];
         wait_for(1'b1);
      end
      rxd_out <= 1'b1;
   endtask
   task automatic grab(input int bclk, output logic [9:0] d);
      wait_for(1'b0);
      repeat (bclk / 2) @(posedge mclk_in);
      for (int i = 0; i < 10; i++)
      begin
         repeat (bclk) @(posedge mclk_in);
         d[i] = txd_in;
      end
   endtask
   // Samples the data pin at each rising shift clock.
   task automatic grab_sync(output logic [7:0] d);
      for (int i = 0; i < 8; i++)
      begin
         wait_for(1'b0);
         wait_for(1'b1);
         d[i] = data_in;
      end
   endtask
endmodule
`default_nettype wire

// ---- sim/serial_port0_uart_tb.sv ----
// Self-checking testbench for serial port 0.
`timescale 1ns/100ps
`default_nettype none
module serial_port0_uart_tb
   import serial_port0_pkg::*;
;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   reg_req_s rq = '0;
   logic tick = 1'b0;
   logic power_fail_irq = 1'b0;
   logic [7:0] rdata, sb;
   logic rxd_o, rxd_oe, txd, far_rxd, pin, irq, pfr;
   logic [9:0] fr;
   int err_count = 0;
   int n_tests = 0;
   assign pin = rxd_oe ? rxd_o : far_rxd;
   always #2.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) tick <= ~tick;
   serial_port0_uart uut (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .reg_req_in(rq), .rdata_out(rdata), .rxd_in(pin), .rxd_out(rxd_o),
      .rxd_oe_out(rxd_oe), .txd_out(txd), .rate_tick_in(tick),
      .power_fail_irq_in(power_fail_irq), .serial_irq_out(irq),
      .power_fail_req_out(pfr));
   serial_far_end far (.mclk_in(mclk_in), .txd_in(txd), .data_in(pin),
      .rxd_out(far_rxd));
   task automatic end_sim;
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [9:0] got,
      input logic [9:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_in);
      rq.wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e,
      input string nm);
      @(posedge mclk_in);
      rq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_in);
      rq.rd <= 1'b0;
      #1;
      chk(nm, {2'b00, rdata}, {2'b00, e});
   endtask
   task automatic t_regs;
      rchk(ADDR_SERIAL_CONTROL, RST_SERIAL_CONTROL, "ctl");
      rchk(ADDR_IRQ_ENABLE, RST_IRQ_ENABLE, "ie");
      rchk(ADDR_SLAVE_VALUE, RST_SLAVE_VALUE, "sv");
      wr(ADDR_SLAVE_VALUE, 8'h5a);
      rchk(ADDR_SLAVE_VALUE, 8'h5a, "sv");
      wr(8'h42, 8'h77);
      rchk(8'h42, READ_UNMAPPED, "unmapped");
      @(posedge mclk_in);
      power_fail_irq <= 1'b1;
      #1;
      chk("pf", {9'h0, pfr}, 10'h001);
      @(posedge mclk_in);
      power_fail_irq <= 1'b0;
   endtask
   task automatic t_m2_tx;
      wr(ADDR_IRQ_ENABLE, 8'h90);
      wr(ADDR_SERIAL_CONTROL, 8'h88);
      fork
         far.grab(64, fr);
         wr(ADDR_SERIAL_BUFFER, 8'ha5);
      join
      chk("frame", fr, 10'h3a5);
      rchk(ADDR_SERIAL_CONTROL, 8'h8a, "ctl");
      chk("irq", {9'h0, irq}, 10'h001);
      wr(ADDR_IRQ_ENABLE, 8'h10);
      chk("irq", {9'h0, irq}, 10'h000);
      wr(ADDR_SERIAL_CONTROL, 8'h88);
      rchk(ADDR_SERIAL_CONTROL, 8'h88, "ctl");
   endtask
   task automatic t_m2_rx;
      wr(ADDR_IRQ_ENABLE, 8'h90);
      wr(ADDR_SLAVE_MASK, 8'hf0);
      wr(ADDR_SERIAL_CONTROL, 8'hb0);
      far.send({2'b10, 8'h5c, 1'b0}, 11, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'hb0, "ctl");
      far.send({2'b11, 8'h6c, 1'b0}, 11, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'hb0, "ctl");
      far.send({2'b11, 8'h53, 1'b0}, 11, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'hb5, "ctl");
      rchk(ADDR_SERIAL_BUFFER, 8'h53, "rxbuf");
      chk("irq", {9'h0, irq}, 10'h001);
      wr(ADDR_SERIAL_CONTROL, 8'h80);
      far.send({2'b11, 8'h33, 1'b0}, 11, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'h80, "ctl");
      rchk(ADDR_SERIAL_BUFFER, 8'h53, "rxbuf");
   endtask
   task automatic t_m1_rx;
      wr(ADDR_SERIAL_CONTROL, 8'h70);
      far.send({2'b00, 8'h11, 1'b0}, 10, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'h70, "ctl");
      far.send({2'b01, 8'h22, 1'b0}, 10, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'h75, "ctl");
      rchk(ADDR_SERIAL_BUFFER, 8'h22, "rxbuf");
      wr(ADDR_POWER_CONTROL, 8'h80);
      far.send({2'b01, 8'h44, 1'b0}, 10, 32);
      rchk(ADDR_SERIAL_BUFFER, 8'h44, "rxbuf");
      wr(ADDR_POWER_CONTROL, 8'h00);
      wr(ADDR_SERIAL_CONTROL, 8'hd0);
      far.send({2'b11, 8'h96, 1'b0}, 11, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'hd5, "ctl");
      rchk(ADDR_SERIAL_BUFFER, 8'h96, "rxbuf");
   endtask
   task automatic t_ferr;
      wr(ADDR_SERIAL_CONTROL, 8'h90);
      wr(ADDR_POWER_CONTROL, 8'h40);
      far.send({2'b01, 8'h11, 1'b0}, 11, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'h95, "ctl");
      far.send({2'b10, 8'h22, 1'b0}, 11, 64);
      rchk(ADDR_SERIAL_CONTROL, 8'h91, "ctl");
      wr(ADDR_SERIAL_CONTROL, 8'h10);
      rchk(ADDR_SERIAL_CONTROL, 8'h10, "ctl");
      wr(ADDR_POWER_CONTROL, 8'h00);
      rchk(ADDR_SERIAL_CONTROL, 8'h90, "ctl");
   endtask
   task automatic t_m0_tx;
      wr(ADDR_SERIAL_CONTROL, 8'h00);
      fork
         far.grab_sync(sb);
         wr(ADDR_SERIAL_BUFFER, 8'h3c);
      join
      chk("sync", {2'b00, sb}, 10'h03c);
      repeat (8) @(posedge mclk_in);
      rchk(ADDR_SERIAL_CONTROL, 8'h02, "ctl");
      chk("oe", {9'h0, rxd_oe}, 10'h000);
      wr(ADDR_SERIAL_CONTROL, 8'h20);
      fork
         far.grab_sync(sb);
         wr(ADDR_SERIAL_BUFFER, 8'hc3);
      join
      chk("sync", {2'b00, sb}, 10'h0c3);
      repeat (4) @(posedge mclk_in);
      rchk(ADDR_SERIAL_CONTROL, 8'h22, "ctl");
      fork
         far.feed_sync(8'h69);
         wr(ADDR_SERIAL_CONTROL, 8'h10);
      join
      repeat (8) @(posedge mclk_in);
      rchk(ADDR_SERIAL_CONTROL, 8'h11, "ctl");
      rchk(ADDR_SERIAL_BUFFER, 8'h69, "rxbuf");
      wr(ADDR_SERIAL_CONTROL, 8'h00);
   endtask
   initial
   begin
      repeat (60000) @(posedge mclk_in);
      err_count++;
      end_sim();
   end
   initial
   begin
      repeat (4) @(posedge mclk_in);
      resetn_in <= 1'b1;
      t_regs();
      t_m2_tx();
      t_m2_rx();
      t_m1_rx();
      t_ferr();
      t_m0_tx();
      end_sim();
   end
endmodule
`default_nettype wire
